// ### ptgt_timer.sv
/*
  Two pairs of 16-bit timers, each pair chainable into one 32-bit timer,
  with an AXI4-Lite register slave. Pair a drives the converter trigger.
  Assumes cpu_sleep and cpu_idle come from logic on aclk; timer pins are
  asynchronous and pass two flip-flops.
*/
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/100ps
// Overview of operation
// - Gate mode counts cycles while gate high
// - Upper timer ignores its gate bit
// - Gate falling edge stops count, keeps value
// - 32-bit period match triggers the converter
// - Prescaler divides by 1, 8, 64, 256
// - Chained mode uses only lower prescaler
// - Count write, timer off, reset clear prescaler
// - Disabled timer halts its prescaler entirely
// - Control writes leave counts untouched
// - No counting during sleep
// - Chained match or gate fall sets upper flag
// - Upper enable bit gates chained interrupt
// - Second pair has no converter trigger
// - Lower word low, upper word high, lower controls
// - Lower inputs, upper flag and enable
// - Control field layout, all zero at reset
// - Chained count wraps to zero at period
// - Lower count read latches upper into hold
// - Lower count write loads upper from hold
module ptgt_timer (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [ptgt_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [ptgt_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic [1:0]                  low_timer_ext_input,
  input  wire logic [1:0]                  high_timer_ext_input,
  input  wire logic                        cpu_sleep,
  input  wire logic                        cpu_idle,
  output logic                             adc_trigger,
  output logic [3:0]                       irq_request
);

  logic [9:0]  aw_idx;
  logic [15:0] wr_val;
  logic [15:0] wr_mask;
  logic        do_write;
  logic        rd_take;
  logic [9:0]  rd_idx;
  logic [3:0]  ext_s1;
  logic [3:0]  ext_s2;
  logic [3:0]  ext_d;
  logic [15:0] cnt  [4];
  logic [15:0] per  [4];
  logic [15:0] con  [4];
  logic [15:0] hold [2];
  logic [15:0] irq_flag_status_0;
  logic [15:0] irq_enable_control_0;
  logic [15:0] ev_vec;
  logic [15:0] flag_clr;
  logic [15:0] pending;
  logic [1:0]  adc_hit;

  function automatic logic [15:0] merge(input logic [15:0] old);
    merge = (old & ~wr_mask) | (wr_val & wr_mask);
  endfunction

  function automatic logic is_mapped(input logic [9:0] idx);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < 4; k++) begin
      if (idx == ptgt_pkg::CNT_IDX[k] || idx == ptgt_pkg::PER_IDX[k]
          || idx == ptgt_pkg::CON_IDX[k]) begin
        hit = 1'b1;
      end
    end
    if (idx == ptgt_pkg::HOLD_IDX[0] || idx == ptgt_pkg::HOLD_IDX[1]
        || idx == ptgt_pkg::IDX_IRQ_FLAG_STATUS_0
        || idx == ptgt_pkg::IDX_IRQ_ENABLE_CONTROL_0) begin
      hit = 1'b1;
    end
    is_mapped = hit;
  endfunction

  // Pin synchronisers; ext_d is only for edge detection on the clean copy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_s1 <= 4'h0;
      ext_s2 <= 4'h0;
      ext_d  <= 4'h0;
    end else begin
      ext_s1 <= {high_timer_ext_input[1], low_timer_ext_input[1],
                 high_timer_ext_input[0], low_timer_ext_input[0]};
      ext_s2 <= ext_s1;
      ext_d  <= ext_s2;
    end
  end

  // Write channel: address and data taken in either order, then one write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= ptgt_pkg::RESP_OKAY;
      aw_idx        <= 10'h000;
      wr_val        <= 16'h0000;
      wr_mask       <= 16'h0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_idx        <= s_axi_awaddr[11:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wr_val       <= s_axi_wdata[15:0];
        wr_mask      <= {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(aw_idx) ? ptgt_pkg::RESP_OKAY : ptgt_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  // Read channel: one cycle from address to data
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign rd_idx  = s_axi_araddr[11:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= ptgt_pkg::RESP_OKAY;
    end else if (rd_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= is_mapped(rd_idx) ? ptgt_pkg::RESP_OKAY : ptgt_pkg::RESP_SLVERR;
      if (rd_idx == ptgt_pkg::IDX_IRQ_FLAG_STATUS_0) begin
        s_axi_rdata <= {16'h0000, irq_flag_status_0};
      end else if (rd_idx == ptgt_pkg::IDX_IRQ_ENABLE_CONTROL_0) begin
        s_axi_rdata <= {16'h0000, irq_enable_control_0};
      end else if (rd_idx == ptgt_pkg::HOLD_IDX[0]) begin
        s_axi_rdata <= {16'h0000, hold[0]};
      end else if (rd_idx == ptgt_pkg::HOLD_IDX[1]) begin
        s_axi_rdata <= {16'h0000, hold[1]};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        for (int k = 0; k < 4; k++) begin
          if (rd_idx == ptgt_pkg::CNT_IDX[k]) begin
            s_axi_rdata <= {16'h0000, cnt[k]};
          end else if (rd_idx == ptgt_pkg::PER_IDX[k]) begin
            s_axi_rdata <= {16'h0000, per[k]};
          end else if (rd_idx == ptgt_pkg::CON_IDX[k]) begin
            s_axi_rdata <= {16'h0000, con[k]};
          end
        end
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Period and control registers, one set per timer
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_regs
      localparam logic [15:0] CMASK = (i % 2 == 0) ? ptgt_pkg::LOW_CON_MASK
                                                    : ptgt_pkg::HIGH_CON_MASK;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          per[i] <= ptgt_pkg::PER_RESET;
          con[i] <= ptgt_pkg::CON_RESET;
        end else if (do_write) begin
          if (aw_idx == ptgt_pkg::PER_IDX[i]) begin
            per[i] <= merge(per[i]);
          end else if (aw_idx == ptgt_pkg::CON_IDX[i]) begin
            con[i] <= merge(con[i]) & CMASK;
          end
        end
      end
    end
  endgenerate

  // Counting logic per pair; timer 2p is the lower word, 2p+1 the upper
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_pair
      localparam int LO = 2 * p;
      localparam int HI = 2 * p + 1;
      ptgt_ps_if ps_lo ();
      ptgt_ps_if ps_hi ();
      logic        chain;
      logic        gate_mode;
      logic        gate_fall;
      logic        cnt_wr;
      logic        on_cleared;
      logic        halt_lo;
      logic        halt_hi;
      logic        tick_lo;
      logic        tick_hi;
      logic        match32;
      logic        match_lo;
      logic        match_hi;
      logic        wr_lo;
      logic        wr_hi;
      logic [15:0] new_lo_con;
      logic [15:0] new_hi_con;

      assign chain     = con[LO][ptgt_pkg::CON_CHAIN];
      // Only the lower gate bit is honoured, also for the chained pair
      assign gate_mode = con[LO][ptgt_pkg::CON_GATE] && !con[LO][ptgt_pkg::CON_CS];
      assign gate_fall = gate_mode && con[LO][ptgt_pkg::CON_ON]
                         && ext_d[LO] && !ext_s2[LO];
      assign wr_lo     = do_write && aw_idx == ptgt_pkg::CNT_IDX[LO];
      assign wr_hi     = do_write && aw_idx == ptgt_pkg::CNT_IDX[HI];
      assign cnt_wr    = wr_lo || wr_hi;
      assign new_lo_con = merge(con[LO]);
      assign new_hi_con = merge(con[HI]);
      assign on_cleared = do_write
        && ((aw_idx == ptgt_pkg::CON_IDX[LO] && con[LO][ptgt_pkg::CON_ON]
             && !new_lo_con[ptgt_pkg::CON_ON])
         || (aw_idx == ptgt_pkg::CON_IDX[HI] && con[HI][ptgt_pkg::CON_ON]
             && !new_hi_con[ptgt_pkg::CON_ON]));
      assign halt_lo = cpu_sleep || (cpu_idle && con[LO][ptgt_pkg::CON_SIDL]);
      assign halt_hi = cpu_sleep || (cpu_idle && con[HI][ptgt_pkg::CON_SIDL]);

      assign ps_lo.run     = con[LO][ptgt_pkg::CON_ON];
      assign ps_lo.clear   = cnt_wr || on_cleared;
      assign ps_lo.sel     = con[LO][ptgt_pkg::CON_PS_HI:ptgt_pkg::CON_PS_LO];
      assign ps_lo.tick_in = !halt_lo && (con[LO][ptgt_pkg::CON_CS]
                             ? (ext_s2[LO] && !ext_d[LO])
                             : (!gate_mode || ext_s2[LO]));
      // Upper prescaler sits idle while chained
      assign ps_hi.run     = con[HI][ptgt_pkg::CON_ON] && !chain;
      assign ps_hi.clear   = cnt_wr || on_cleared;
      assign ps_hi.sel     = con[HI][ptgt_pkg::CON_PS_HI:ptgt_pkg::CON_PS_LO];
      assign ps_hi.tick_in = !halt_hi && (!con[HI][ptgt_pkg::CON_CS]
                             || (ext_s2[HI] && !ext_d[HI]));

      ptgt_prescaler u_ps_lo (.aclk(aclk), .aresetn(aresetn), .ps(ps_lo));
      ptgt_prescaler u_ps_hi (.aclk(aclk), .aresetn(aresetn), .ps(ps_hi));

      assign tick_lo  = ps_lo.tick_out;
      assign tick_hi  = ps_hi.tick_out;
      assign match32  = {cnt[HI], cnt[LO]} == {per[HI], per[LO]};
      assign match_lo = cnt[LO] == per[LO];
      assign match_hi = cnt[HI] == per[HI];

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cnt[LO] <= ptgt_pkg::CNT_RESET;
        end else if (wr_lo) begin
          cnt[LO] <= merge(cnt[LO]);
        end else if (tick_lo) begin
          cnt[LO] <= (chain ? match32 : match_lo) ? 16'h0000 : cnt[LO] + 16'h0001;
        end
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cnt[HI] <= ptgt_pkg::CNT_RESET;
        end else if (wr_hi) begin
          cnt[HI] <= merge(cnt[HI]);
        end else if (wr_lo && chain) begin
          cnt[HI] <= hold[p];
        end else if (chain) begin
          if (tick_lo && match32) begin
            cnt[HI] <= 16'h0000;
          end else if (tick_lo && cnt[LO] == 16'hFFFF) begin
            cnt[HI] <= cnt[HI] + 16'h0001;
          end
        end else if (tick_hi) begin
          cnt[HI] <= match_hi ? 16'h0000 : cnt[HI] + 16'h0001;
        end
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          hold[p] <= ptgt_pkg::CNT_RESET;
        end else if (do_write && aw_idx == ptgt_pkg::HOLD_IDX[p]) begin
          hold[p] <= merge(hold[p]);
        end else if (rd_take && rd_idx == ptgt_pkg::CNT_IDX[LO] && chain) begin
          hold[p] <= cnt[HI];
        end
      end

      // Chained events land on the upper timer's flag
      assign ev_vec[ptgt_pkg::IRQ_BIT[HI]] = chain ? ((tick_lo && match32) || gate_fall)
                                                   : (tick_hi && match_hi);
      assign ev_vec[ptgt_pkg::IRQ_BIT[LO]] = !chain && ((tick_lo && match_lo) || gate_fall);

      if (p == 0) begin : g_adc
        assign adc_hit[p] = chain && tick_lo && match32;
      end else begin : g_no_adc
        assign adc_hit[p] = 1'b0;
      end
    end
  endgenerate

  assign ev_vec[5:0]   = 6'h00;
  assign ev_vec[10:8]  = 3'h0;
  assign ev_vec[15:13] = 3'h0;

  // Write one to clear; a same-cycle event wins over the clear
  assign flag_clr = (do_write && aw_idx == ptgt_pkg::IDX_IRQ_FLAG_STATUS_0)
                    ? (wr_val & wr_mask) : 16'h0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_flag_status_0 <= 16'h0000;
    end else begin
      irq_flag_status_0 <= ((irq_flag_status_0 & ~flag_clr) | ev_vec)
                           & ptgt_pkg::IRQ_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_enable_control_0 <= 16'h0000;
    end else if (do_write && aw_idx == ptgt_pkg::IDX_IRQ_ENABLE_CONTROL_0) begin
      irq_enable_control_0 <= merge(irq_enable_control_0) & ptgt_pkg::IRQ_MASK;
    end
  end

  assign pending = irq_flag_status_0 & irq_enable_control_0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_request <= 4'h0;
      adc_trigger <= 1'b0;
    end else begin
      irq_request <= {pending[ptgt_pkg::IRQ_BIT[3]], pending[ptgt_pkg::IRQ_BIT[2]],
                      pending[ptgt_pkg::IRQ_BIT[1]], pending[ptgt_pkg::IRQ_BIT[0]]};
      adc_trigger <= adc_hit[0];
    end
  end

endmodule // ptgt_timer

// ### ptgt_pkg.sv
/*
  Constants for the paired general-purpose timer block: register indices,
  control field positions, reset values, prescaler terminals and bus answers.
  Assumes the AXI4-Lite byte address of a register is four times its index.
*/
package ptgt_pkg;

  localparam int ADDR_W = 12;

  // Register indices; byte address is index * 4
  localparam logic [9:0] IDX_A_LOW_COUNT   = 10'h106;
  localparam logic [9:0] IDX_A_HIGH_HOLD   = 10'h108;
  localparam logic [9:0] IDX_A_HIGH_COUNT  = 10'h10A;
  localparam logic [9:0] IDX_A_LOW_PERIOD  = 10'h10C;
  localparam logic [9:0] IDX_A_HIGH_PERIOD = 10'h10E;
  localparam logic [9:0] IDX_A_LOW_CONTROL = 10'h110;
  localparam logic [9:0] IDX_A_HIGH_CONTROL = 10'h112;
  localparam logic [9:0] IDX_B_LOW_COUNT   = 10'h114;
  localparam logic [9:0] IDX_B_HIGH_HOLD   = 10'h116;
  localparam logic [9:0] IDX_B_HIGH_COUNT  = 10'h118;
  localparam logic [9:0] IDX_B_LOW_PERIOD  = 10'h11A;
  localparam logic [9:0] IDX_B_HIGH_PERIOD = 10'h11C;
  localparam logic [9:0] IDX_B_LOW_CONTROL = 10'h11E;
  localparam logic [9:0] IDX_B_HIGH_CONTROL = 10'h120;
  localparam logic [9:0] IDX_IRQ_FLAG_STATUS_0   = 10'h124;
  localparam logic [9:0] IDX_IRQ_ENABLE_CONTROL_0 = 10'h126;

  // Timer order: 0 pair a low, 1 pair a high, 2 pair b low, 3 pair b high
  localparam logic [3:0][9:0] CNT_IDX = {IDX_B_HIGH_COUNT, IDX_B_LOW_COUNT,
                                         IDX_A_HIGH_COUNT, IDX_A_LOW_COUNT};
  localparam logic [3:0][9:0] PER_IDX = {IDX_B_HIGH_PERIOD, IDX_B_LOW_PERIOD,
                                         IDX_A_HIGH_PERIOD, IDX_A_LOW_PERIOD};
  localparam logic [3:0][9:0] CON_IDX = {IDX_B_HIGH_CONTROL, IDX_B_LOW_CONTROL,
                                         IDX_A_HIGH_CONTROL, IDX_A_LOW_CONTROL};
  localparam logic [1:0][9:0] HOLD_IDX = {IDX_B_HIGH_HOLD, IDX_A_HIGH_HOLD};

  // Control register fields
  localparam int CON_ON    = 15;
  localparam int CON_SIDL  = 13;
  localparam int CON_GATE  = 6;
  localparam int CON_PS_HI = 5;
  localparam int CON_PS_LO = 4;
  localparam int CON_CHAIN = 3;
  localparam int CON_CS    = 1;
  localparam logic [15:0] LOW_CON_MASK  = 16'hA07A;
  localparam logic [15:0] HIGH_CON_MASK = 16'hA072;

  localparam logic [15:0] CON_RESET = 16'h0000;
  localparam logic [15:0] PER_RESET = 16'hFFFF;
  localparam logic [15:0] CNT_RESET = 16'h0000;

  // Interrupt flag / enable bit per timer
  localparam logic [3:0][3:0] IRQ_BIT = {4'hC, 4'hB, 4'h7, 4'h6};
  localparam logic [15:0] IRQ_MASK = 16'h18C0;

  // Prescaler terminal count for 1:1, 1:8, 1:64, 1:256
  localparam logic [3:0][7:0] PS_LAST = {8'hFF, 8'h3F, 8'h07, 8'h00};

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### ptgt_ps_if.sv
/*
  Carrier between a timer and its prescaler: input tick, clear, run, ratio
  select and the divided tick. Both ends share one clock.
*/
`timescale 1ns/100ps
interface ptgt_ps_if;
  logic       tick_in;
  logic       clear;
  logic       run;
  logic [1:0] sel;
  logic       tick_out;
  modport ctrl (output tick_in, output clear, output run, output sel, input tick_out);
  modport pre  (input tick_in, input clear, input run, input sel, output tick_out);
endinterface

// ### ptgt_prescaler.sv
/*
  Timer input prescaler dividing by 1, 8, 64 or 256.
  Assumes tick_in is already synchronous to aclk.
*/
`timescale 1ns/100ps
module ptgt_prescaler (
  input wire logic aclk,
  input wire logic aresetn,
  ptgt_ps_if.pre   ps
);

  logic [7:0] count;
  logic       at_last;

  assign at_last = (count >= ptgt_pkg::PS_LAST[ps.sel]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 8'h00;
    end else if (ps.run) begin
      if (ps.clear) begin
        count <= 8'h00;
      end else if (ps.tick_in) begin
        count <= at_last ? 8'h00 : count + 8'h01;
      end
    end
  end

  assign ps.tick_out = ps.run && ps.tick_in && !ps.clear && at_last;

endmodule // ptgt_prescaler

// ### ptgt_timer_monitor.sv
/*
  Checker for the paired timer block: bus answer timing and trigger shape.
  Assumes it is bound to ptgt_timer and sees only its ports.
*/
`timescale 1ns/100ps
module ptgt_timer_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        adc_trigger
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_trig_single;
    adc_trigger |=> !adc_trigger;
  endproperty
  a_trig_single: assert property (p_trig_single)
    else $error("adc_trigger high for more than one cycle");

  property p_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_take: assert property (p_wr_take)
    else $error("write response not two cycles after address and data");

  property p_rd_take;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_take: assert property (p_rd_take)
    else $error("read answer not one cycle after address");

  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped or changed while stalled");

  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read answer dropped or changed while stalled");

  property p_r_upper;
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
  endproperty
  a_r_upper: assert property (p_r_upper)
    else $error("read data upper half not zero");

  property p_aw_closed;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_closed: assert property (p_aw_closed)
    else $error("write channels open while response pending");

  property p_b_release;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_release: assert property (p_b_release)
    else $error("write response held after handshake");

  c_trig: cover property (adc_trigger);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_r_stall: cover property (s_axi_rvalid && !s_axi_rready);
endmodule // ptgt_timer_monitor

bind ptgt_timer ptgt_timer_monitor u_monitor (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .adc_trigger(adc_trigger)
);

// ### ptgt_timer_test.sv
/*
  Self-checking bench for the paired timer block over AXI4-Lite.
  Assumes the checker is bound in; idle and upper pins are held low.
*/
`timescale 1ns/100ps
module ptgt_timer_test;
  logic        aclk, aresetn, sleep, trig;
  logic [11:0] awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rd_data;
  logic [1:0]  bresp, rresp, ext_lo, last_resp, last_rresp;
  logic [3:0]  irq;
  int          fails, checked;

  ptgt_timer u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .low_timer_ext_input(ext_lo), .high_timer_ext_input(2'h0), .cpu_sleep(sleep),
    .cpu_idle(1'b0), .adc_trigger(trig), .irq_request(irq)
  );

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic conclude;
    $display("Comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // Response ready rides with the request; only the watchdog ends a wait
  task automatic wr(input logic [9:0] i, input logic [15:0] d);
    @(posedge aclk);
    awaddr <= {i, 2'b00};
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        last_resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [9:0] i);
    @(posedge aclk);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        rd_data = rdata;
        last_rresp = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rc(input logic [9:0] i, input logic [31:0] e, input string n);
    rd(i);
    chk(n, e, rd_data);
  endtask

  // Cycles from now to the next trigger pulse
  task automatic gap(output int n);
    n = 0;
    for (int k = 0; k < 2000; k++) begin
      @(posedge aclk);
      n++;
      if (trig === 1'b1) break;
    end
  endtask

  task automatic pulses(input int c, output int n);
    n = 0;
    repeat (c) begin
      @(posedge aclk);
      if (trig !== 1'b0) n++;
    end
  endtask

  task automatic t_reset;
    rc(ptgt_pkg::IDX_A_LOW_CONTROL, 16'h0000, "low control reset");
    rc(ptgt_pkg::IDX_B_HIGH_PERIOD, 16'hFFFF, "period reset");
    wr(ptgt_pkg::IDX_A_LOW_CONTROL, 16'hFFFF);
    rc(ptgt_pkg::IDX_A_LOW_CONTROL, 16'hA07A, "low control fields");
    wr(ptgt_pkg::IDX_A_HIGH_CONTROL, 16'hFFFF);
    chk("mapped bresp", ptgt_pkg::RESP_OKAY, last_resp);
    rc(ptgt_pkg::IDX_A_HIGH_CONTROL, 16'hA072, "high control fields");
    wr(ptgt_pkg::IDX_A_LOW_CONTROL, 16'h0000);
    wr(ptgt_pkg::IDX_A_HIGH_CONTROL, 16'h0000);
    wr(10'h3FF, 16'h0001);
    chk("unmapped bresp", ptgt_pkg::RESP_SLVERR, last_resp);
    rd(10'h3FF);
    chk("unmapped rresp", ptgt_pkg::RESP_SLVERR, last_rresp);
    chk("unmapped rdata", 32'h0000_0000, rd_data);
  endtask

  task automatic t_coherent;
    wr(ptgt_pkg::IDX_A_LOW_CONTROL, 16'h0008);
    wr(ptgt_pkg::IDX_A_HIGH_HOLD, 16'h1234);
    wr(ptgt_pkg::IDX_A_LOW_COUNT, 16'h0005);
    rc(ptgt_pkg::IDX_A_HIGH_COUNT, 16'h1234, "upper count from hold");
    wr(ptgt_pkg::IDX_A_HIGH_COUNT, 16'hBEEF);
    rc(ptgt_pkg::IDX_A_LOW_COUNT, 16'h0005, "lower count");
    rc(ptgt_pkg::IDX_A_HIGH_HOLD, 16'hBEEF, "hold latched on read");
  endtask

  task automatic t_chain;
    int div [4] = '{1, 8, 64, 256};
    int n;
    logic [31:0] c;
    wr(ptgt_pkg::IDX_IRQ_ENABLE_CONTROL_0, 16'h0080);
    // Leftover upper word would push the match past the whole 32-bit wrap
    wr(ptgt_pkg::IDX_A_HIGH_HOLD, 16'h0000);
    wr(ptgt_pkg::IDX_A_LOW_COUNT, 16'h0000);
    wr(ptgt_pkg::IDX_A_HIGH_PERIOD, 16'h0000);
    wr(ptgt_pkg::IDX_A_LOW_PERIOD, 16'h0002);
    wr(ptgt_pkg::IDX_A_HIGH_CONTROL, 16'h0030);
    for (int k = 0; k < 4; k++) begin
      wr(ptgt_pkg::IDX_A_LOW_CONTROL, {8'h80, 2'b00, k[1:0], 4'h8});
      gap(n);
      gap(n);
      chk("trigger spacing", 3 * div[k], n);
    end
    rd(ptgt_pkg::IDX_IRQ_FLAG_STATUS_0);
    chk("match flag", 1'b1, rd_data[7]);
    chk("irq enabled", 1'b1, irq[1]);
    wr(ptgt_pkg::IDX_A_LOW_CONTROL, 16'h0008);
    rd(ptgt_pkg::IDX_A_LOW_COUNT);
    c = rd_data;
    wr(ptgt_pkg::IDX_A_LOW_CONTROL, 16'h0018);
    rc(ptgt_pkg::IDX_A_LOW_COUNT, c, "count after control write");
    chk("flag kept", 1'b1, irq[1]);
    wr(ptgt_pkg::IDX_IRQ_FLAG_STATUS_0, 16'h0080);
    @(negedge aclk);
    chk("irq after clear", 1'b0, irq[1]);
    wr(ptgt_pkg::IDX_A_LOW_CONTROL, 16'h8008);
    sleep <= 1'b1;
    @(posedge aclk);
    pulses(30, n);
    chk("triggers in sleep", 0, n);
    sleep <= 1'b0;
    wr(ptgt_pkg::IDX_A_LOW_CONTROL, 16'h0008);
  endtask

  task automatic t_pair_b;
    int n;
    wr(ptgt_pkg::IDX_IRQ_FLAG_STATUS_0, 16'hFFFF);
    wr(ptgt_pkg::IDX_IRQ_ENABLE_CONTROL_0, 16'h1000);
    wr(ptgt_pkg::IDX_B_HIGH_PERIOD, 16'h0000);
    wr(ptgt_pkg::IDX_B_LOW_PERIOD, 16'h0002);
    wr(ptgt_pkg::IDX_B_LOW_CONTROL, 16'h8008);
    pulses(40, n);
    chk("second pair triggers", 0, n);
    rd(ptgt_pkg::IDX_IRQ_FLAG_STATUS_0);
    chk("second pair flag", 1'b1, rd_data[12]);
    @(negedge aclk);
    chk("second pair irq", 1'b1, irq[3]);
    wr(ptgt_pkg::IDX_B_LOW_CONTROL, 16'h0000);
  endtask

  task automatic t_gate;
    logic [31:0] c;
    wr(ptgt_pkg::IDX_A_HIGH_PERIOD, 16'hFFFF);
    wr(ptgt_pkg::IDX_A_LOW_PERIOD, 16'hFFFF);
    wr(ptgt_pkg::IDX_IRQ_FLAG_STATUS_0, 16'hFFFF);
    wr(ptgt_pkg::IDX_A_LOW_CONTROL, 16'h0048);
    wr(ptgt_pkg::IDX_A_HIGH_HOLD, 16'h0000);
    wr(ptgt_pkg::IDX_A_LOW_COUNT, 16'h0000);
    wr(ptgt_pkg::IDX_A_LOW_CONTROL, 16'h8048);
    ext_lo[0] <= 1'b1;
    repeat (10) @(posedge aclk);
    ext_lo[0] <= 1'b0;
    repeat (10) @(posedge aclk);
    rd(ptgt_pkg::IDX_A_LOW_COUNT);
    c = rd_data;
    checked++;
    if (c < 9 || c > 11) begin
      fails++;
      $display("Error gated count expected 10 seen %h", c);
    end
    repeat (10) @(posedge aclk);
    rc(ptgt_pkg::IDX_A_LOW_COUNT, c, "count held after gate");
    rd(ptgt_pkg::IDX_IRQ_FLAG_STATUS_0);
    chk("gate fall flag", 1'b1, rd_data[7]);
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    conclude;
  end

  initial begin
    {aresetn, sleep, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, ext_lo} = '0;
    fails = 0;
    checked = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_coherent;
    t_chain;
    t_pair_b;
    t_gate;
    conclude;
  end
endmodule // ptgt_timer_test
